// [verilog/wave_ctrl_pkg.sv]
package wave_ctrl_pkg;
	// apb register byte offsets
	localparam logic [7:0] ctrl_a_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] mask_off = 8'h08;
	localparam logic [7:0] state_off = 8'h0C;
	// waveform_ctrl_a field positions
	localparam int out_mode_a_lsb = 6;
	localparam int out_mode_b_lsb = 4;
	localparam int wave_mode_lo_lsb = 0;
	// writable bits of waveform_ctrl_a; bits 3:2 are held at zero
	localparam logic [7:0] ctrl_a_wmask = 8'hF3;
	localparam logic [7:0] ctrl_a_reset = 8'h00;
	// status / mask bit positions
	localparam int ev_ovf = 0;
	localparam int ev_match_a = 1;
	localparam int ev_match_b = 2;
	localparam int ev_count = 3;
	localparam logic [ev_count-1:0] ev_reset = 3'h0;
	// fixed count limits
	localparam logic [15:0] count_max = 16'hFFFF;
	localparam logic [15:0] count_bottom = 16'h0000;
	localparam logic [15:0] top_8bit = 16'h00FF;
	localparam logic [15:0] top_9bit = 16'h01FF;
	localparam logic [15:0] top_10bit = 16'h03FF;
	// output mode field codes
	localparam logic [1:0] om_off = 2'h0;
	localparam logic [1:0] om_toggle = 2'h1;
	localparam logic [1:0] om_clear = 2'h2;
	localparam logic [1:0] om_set = 2'h3;
	// waveform mode numbers
	localparam logic [3:0] wm_normal = 4'h0;
	localparam logic [3:0] wm_clr_match = 4'h4;
	localparam logic [3:0] wm_pfc_cap = 4'h8;
	localparam logic [3:0] wm_pfc_match = 4'h9;
	localparam logic [3:0] wm_pc_cap = 4'hA;
	localparam logic [3:0] wm_pc_match = 4'hB;
	localparam logic [3:0] wm_clr_cap = 4'hC;
	localparam logic [3:0] wm_reserved = 4'hD;
	localparam logic [3:0] wm_fast_cap = 4'hE;
	localparam logic [3:0] wm_fast_match = 4'hF;
	// waveform class of a mode
	typedef enum logic [2:0] {
		cls_normal,
		cls_clr,
		cls_fast,
		cls_phase,
		cls_phase_freq,
		cls_reserved
	} wave_cls_t;
	// where compare values reload
	typedef enum logic [1:0] {
		load_now,
		load_top,
		load_bottom
	} load_pt_t;
	// where the overflow event fires
	typedef enum logic [1:0] {
		ovf_max,
		ovf_top,
		ovf_bottom
	} ovf_pt_t;
endpackage

// [verilog/timer16_waveform_mode_control.sv]
`timescale 1ns/100ps
// Contract
// R1: nonzero out_mode_a hands pin to wave_out_a
// R2: nonzero out_mode_b hands pin to wave_out_b
// R3: pin driver enabled only by direction bit
// R4: non-pwm: off, toggle, clear, set on match
// R5: fast pwm 01: toggle a in 14/15
// R6: fast pwm 10: clear on match, set at top
// R7: fast pwm 11: set on match, clear at top
// R8: fast pwm match at top ignored, top action kept
// R9: dual-slope 01: toggle a in 8..11
// R10: dual-slope 10: clear up, set down
// R11: dual-slope 11: set up, clear down
// R12: wave_mode joins low and high mode bits
// R13: normal and clear-on-match tops, immediate load, max flag
// R14: modes 1-3 phase correct fixed tops
// R15: modes 5-7 fast pwm fixed tops
// R16: modes 8/9 phase-freq correct, bottom load/flag
// R17: 10/11 phase, 14/15 fast, 13 reserved
// R18: dual-slope compare bottom/top holds output
// R19: ctrl bits 3:2 read zero, reset zero
module timer16_waveform_mode_control
	import wave_ctrl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] wave_mode_hi,
	input wire logic [15:0] count_value,
	input wire logic count_tick,
	input wire logic count_down,
	input wire logic [15:0] match_value_a,
	input wire logic [15:0] match_value_b,
	input wire logic [15:0] capture_value,
	input wire logic port_data_a,
	input wire logic port_data_b,
	input wire logic port_dir_a,
	input wire logic port_dir_b,
	output logic [15:0] top_value,
	output logic dual_slope,
	output logic capture_is_top,
	output logic [1:0] load_point,
	output logic overflow_event,
	output logic pin_a_out,
	output logic pin_a_oe,
	output logic pin_b_out,
	output logic pin_b_oe,
	output logic irq
);

	// register state
	logic [7:0] ctrl_a_r, ctrl_a_nxt; // waveform_ctrl_a, bits 3:2 always zero
	logic [ev_count-1:0] status_r, status_nxt; // sticky event flags
	logic [ev_count-1:0] mask_r, mask_nxt; // interrupt enables
	logic [31:0] rdata_r, rdata_nxt; // read data latched in setup phase
	// waveform and pin state
	logic wave_a_r, wave_a_nxt;
	logic wave_b_r, wave_b_nxt;
	logic pin_a_r, pin_a_nxt;
	logic pin_b_r, pin_b_nxt;
	logic oe_a_r, oe_a_nxt;
	logic oe_b_r, oe_b_nxt;
	// decoded fields
	logic [1:0] out_mode_a, out_mode_b;
	logic [3:0] wave_mode;
	wave_cls_t cls;
	load_pt_t load_pt;
	ovf_pt_t ovf_pt;
	logic [15:0] top_sel;
	// counter events
	logic at_top, at_bottom, at_max;
	logic match_a, match_b;
	logic own_a, own_b;
	logic toggle_ok_a;
	// bus decode
	logic setup_ph, wr_en, addr_ok;
	logic [ev_count-1:0] ev_now;

	assign out_mode_a = ctrl_a_r[out_mode_a_lsb +: 2];
	assign out_mode_b = ctrl_a_r[out_mode_b_lsb +: 2];
	assign wave_mode = {wave_mode_hi, ctrl_a_r[wave_mode_lo_lsb +: 2]}; // [R12]

	// mode table: class, top source, reload point, overflow point
	always_comb begin
		cls = cls_reserved;
		top_sel = count_max;
		load_pt = load_now;
		ovf_pt = ovf_max;
		capture_is_top = 1'b0;
		case (wave_mode)
			wm_normal: begin
				cls = cls_normal; // [R13]
				top_sel = count_max;
			end
			4'h1, 4'h2, 4'h3: begin
				cls = cls_phase; // [R14]
				load_pt = load_top;
				ovf_pt = ovf_bottom;
				top_sel = (wave_mode == 4'h1) ? top_8bit :
					(wave_mode == 4'h2) ? top_9bit : top_10bit;
			end
			wm_clr_match: begin
				cls = cls_clr; // [R13]
				top_sel = match_value_a;
			end
			4'h5, 4'h6, 4'h7: begin
				cls = cls_fast; // [R15]
				load_pt = load_top;
				ovf_pt = ovf_top;
				top_sel = (wave_mode == 4'h5) ? top_8bit :
					(wave_mode == 4'h6) ? top_9bit : top_10bit;
			end
			wm_pfc_cap, wm_pfc_match: begin
				cls = cls_phase_freq; // [R16]
				load_pt = load_bottom;
				ovf_pt = ovf_bottom;
				capture_is_top = (wave_mode == wm_pfc_cap);
				top_sel = capture_is_top ? capture_value : match_value_a;
			end
			wm_pc_cap, wm_pc_match: begin
				cls = cls_phase; // [R17]
				load_pt = load_top;
				ovf_pt = ovf_bottom;
				capture_is_top = (wave_mode == wm_pc_cap);
				top_sel = capture_is_top ? capture_value : match_value_a;
			end
			wm_clr_cap: begin
				cls = cls_clr; // [R13]
				capture_is_top = 1'b1;
				top_sel = capture_value;
			end
			wm_fast_cap, wm_fast_match: begin
				cls = cls_fast; // [R17]
				load_pt = load_top;
				ovf_pt = ovf_top;
				capture_is_top = (wave_mode == wm_fast_cap);
				top_sel = capture_is_top ? capture_value : match_value_a;
			end
			// mode 13 is reserved: waveform held, no overflow event
			default: begin
				cls = cls_reserved; // [R17]
			end
		endcase
	end

	assign top_value = top_sel;
	assign dual_slope = (cls == cls_phase) || (cls == cls_phase_freq);
	assign load_point = load_pt;

	// counter position events; only the matches are qualified by the timer tick
	assign at_top = (count_value == top_sel);
	assign at_bottom = (count_value == count_bottom);
	assign at_max = (count_value == count_max);
	assign match_a = count_tick && (count_value == match_value_a);
	assign match_b = count_tick && (count_value == match_value_b);

	// overflow event at the point set by the mode
	always_comb begin
		case (ovf_pt)
			ovf_top: overflow_event = count_tick && at_top; // [R15]
			ovf_bottom: overflow_event = count_tick && at_bottom && count_down; // [R14] [R16]
			default: overflow_event = count_tick && at_max && (cls != cls_reserved); // [R13]
		endcase
	end

	// toggle in pwm is only offered on channel a, and only for some modes
	always_comb begin
		case (cls)
			cls_fast: toggle_ok_a = (wave_mode == wm_fast_cap) ||
				(wave_mode == wm_fast_match); // [R5]
			cls_phase, cls_phase_freq: toggle_ok_a = (wave_mode >= wm_pfc_cap) &&
				(wave_mode <= wm_pc_match); // [R9]
			default: toggle_ok_a = 1'b1;
		endcase
	end

	// pin ownership: any nonzero field, except a refused pwm toggle or the reserved mode
	always_comb begin
		own_a = (out_mode_a != om_off); // [R1]
		own_b = (out_mode_b != om_off); // [R2]
		if (cls == cls_reserved) begin
			own_a = 1'b0;
			own_b = 1'b0;
		end else if (cls != cls_normal && cls != cls_clr) begin
			if (out_mode_a == om_toggle && !toggle_ok_a)
				own_a = 1'b0; // [R5] [R9]
			if (out_mode_b == om_toggle)
				own_b = 1'b0; // [R5] [R9]
		end
	end

	// next waveform level for one channel from its mode and counter events
	function automatic logic wave_step(input wave_cls_t c, input logic [1:0] om,
		input logic cur, input logic hit, input logic cmp_top, input logic cmp_zero);
		logic nv;
		nv = cur;
		case (c)
			cls_normal, cls_clr: begin
				if (hit) begin
					case (om)
						om_toggle: nv = !cur; // [R4]
						om_clear: nv = 1'b0; // [R4]
						om_set: nv = 1'b1; // [R4]
						default: nv = cur;
					endcase
				end
			end
			cls_fast: begin
				if (om == om_toggle) begin
					if (hit)
						nv = !cur; // [R5]
				end else if (om[1]) begin
					// top action first; a match sitting on top is dropped
					if (count_tick && at_top)
						nv = (om == om_clear); // [R6] [R7] [R8]
					else if (hit && !cmp_top)
						nv = (om == om_set); // [R6] [R7] [R8]
				end
			end
			cls_phase, cls_phase_freq: begin
				if (om == om_toggle) begin
					if (hit)
						nv = !cur; // [R9]
				end else if (om[1]) begin
					// extreme compare values pin the output for the whole period
					if (cmp_zero && count_tick && at_bottom)
						nv = (om == om_set); // [R18]
					else if (cmp_top && count_tick && at_top)
						nv = (om == om_clear); // [R18]
					else if (hit && !cmp_zero && !cmp_top)
						nv = count_down ? (om == om_clear) : (om == om_set); // [R10] [R11]
				end
			end
			default: nv = cur;
		endcase
		return nv;
	endfunction

	// waveform and pin next state
	always_comb begin
		wave_a_nxt = wave_step(cls, out_mode_a, wave_a_r, match_a,
			match_value_a == top_sel, match_value_a == count_bottom);
		wave_b_nxt = wave_step(cls, out_mode_b, wave_b_r, match_b,
			match_value_b == top_sel, match_value_b == count_bottom);
		pin_a_nxt = own_a ? wave_a_r : port_data_a; // [R1]
		pin_b_nxt = own_b ? wave_b_r : port_data_b; // [R2]
		// the driver follows the direction bit even while the compare owns the pin
		oe_a_nxt = port_dir_a; // [R3]
		oe_b_nxt = port_dir_b; // [R3]
	end

	// waveform and pin registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
			pin_a_r <= 1'b0;
			pin_b_r <= 1'b0;
			oe_a_r <= 1'b0;
			oe_b_r <= 1'b0;
		end else begin
			wave_a_r <= wave_a_nxt;
			wave_b_r <= wave_b_nxt;
			pin_a_r <= pin_a_nxt;
			pin_b_r <= pin_b_nxt;
			oe_a_r <= oe_a_nxt;
			oe_b_r <= oe_b_nxt;
		end
	end

	assign pin_a_out = pin_a_r;
	assign pin_b_out = pin_b_r;
	assign pin_a_oe = oe_a_r;
	assign pin_b_oe = oe_b_r;

	// apb decode: zero wait states, read data fetched during setup
	assign setup_ph = psel && !penable;
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign addr_ok = (paddr == ctrl_a_off) || (paddr == status_off) ||
		(paddr == mask_off) || (paddr == state_off);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// event vector feeding the sticky status
	assign ev_now = {match_b, match_a, overflow_event};

	// register file next state
	always_comb begin
		ctrl_a_nxt = ctrl_a_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		rdata_nxt = rdata_r;
		if (wr_en && paddr == ctrl_a_off)
			ctrl_a_nxt = pwdata[7:0] & ctrl_a_wmask; // [R19]
		if (wr_en && paddr == mask_off)
			mask_nxt = pwdata[ev_count-1:0];
		// write-one clears, but a new event in the same cycle wins
		if (wr_en && paddr == status_off)
			status_nxt = status_r & ~pwdata[ev_count-1:0];
		status_nxt = status_nxt | ev_now;
		if (setup_ph) begin
			case (paddr)
				ctrl_a_off: rdata_nxt = {24'h000000, ctrl_a_r}; // [R19]
				status_off: rdata_nxt = {29'h00000000, status_r};
				mask_off: rdata_nxt = {29'h00000000, mask_r};
				state_off: rdata_nxt = {top_sel, 4'h0, own_b, own_a,
					wave_b_r, wave_a_r, 1'b0, cls, wave_mode};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_r <= ctrl_a_reset; // [R19]
			status_r <= ev_reset;
			mask_r <= ev_reset;
			rdata_r <= 32'h00000000;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign prdata = rdata_r;
	assign irq = |(status_r & mask_r);

endmodule

// [bench/pin_pad_model.sv]
`timescale 1ns/100ps
// port pad with a weak pull-up behind the block's pin driver
module pin_pad_model (
	input wire logic drv, // level from the block
	input wire logic en, // driver enable from the block
	output logic pad // level seen on the pin
);
	// an undriven pad must not hold the last level, so the pull-up wins
	assign pad = en ? drv : 1'b1;
endmodule

// [bench/wave_ctrl_checker_sva.sv]
`timescale 1ns/100ps
module wave_ctrl_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic port_dir_a,
	input wire logic port_dir_b,
	input wire logic pin_a_oe,
	input wire logic pin_b_oe,
	input wire logic [15:0] count_value,
	input wire logic count_tick,
	input wire logic count_down,
	input wire logic [15:0] capture_value,
	input wire logic [15:0] top_value,
	input wire logic dual_slope,
	input wire logic capture_is_top,
	input wire logic [1:0] load_point,
	input wire logic overflow_event
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// drivers follow the direction bits one edge later
	oe_a_a: assert property ($past(presetn) |-> pin_a_oe == $past(port_dir_a))
		else $error("pin a enable differs from direction");
	oe_b_a: assert property ($past(presetn) |-> pin_b_oe == $past(port_dir_b))
		else $error("pin b enable differs from direction");
	// overflow only on a timer tick, at the point its mode names
	ovf_tick_a: assert property (overflow_event |-> count_tick)
		else $error("overflow without tick");
	ovf_max_a: assert property (overflow_event && load_point == 2'h0
		|-> count_value == 16'hFFFF) else $error("overflow off max");
	ovf_bot_a: assert property (overflow_event && dual_slope
		|-> !count_value && count_down) else $error("overflow off bottom");
	ovf_top_a: assert property (overflow_event && !dual_slope && load_point == 2'h1
		|-> count_value == top_value) else $error("overflow off top");
	// mode decode consistency
	cap_top_a: assert property (capture_is_top |-> top_value == capture_value)
		else $error("top not from capture");
	bot_load_a: assert property (load_point == 2'h2 |-> dual_slope)
		else $error("bottom reload outside dual slope");
	dual_load_a: assert property (dual_slope |-> load_point != 2'h0)
		else $error("immediate reload in dual slope");
endmodule
bind timer16_waveform_mode_control wave_ctrl_checker chk_i (.*);

// [bench/timer16_waveform_mode_control_test.sv]
`timescale 1ns/100ps
module timer16_waveform_mode_control_test;
	import wave_ctrl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, count_tick, count_down;
	logic port_data_a, port_data_b, port_dir_a, port_dir_b, dual_slope, capture_is_top;
	logic overflow_event, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, irq, pad_a, pad_b, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] count_value, match_value_a, match_value_b, capture_value, top_value;
	logic [1:0] wave_mode_hi, load_point;
	int n_fail = 0;
	int checks = 0;
	int md;
	// class and reload point per mode, one nibble each, mode 0 lowest
	localparam logic [63:0] cls_s = 64'h2251_3344_2221_3330;
	localparam logic [63:0] ld_s = 64'h1100_1122_1110_1110;
	// expected top with match a 0x0100 and capture 0x0ABC
	logic [15:0] top_tab [16] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF, 16'h0100, 16'h00FF,
		16'h01FF, 16'h03FF, 16'h0ABC, 16'h0100, 16'h0ABC, 16'h0100, 16'h0ABC, 16'h0000,
		16'h0ABC, 16'h0100};
	timer16_waveform_mode_control uut (.*);
	pin_pad_model pad_a_m (.drv(pin_a_out), .en(pin_a_oe), .pad(pad_a));
	pin_pad_model pad_b_m (.drv(pin_b_out), .en(pin_b_oe), .pad(pad_b));
	// free running clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb transfer with an idle cycle before, so psel is never reassigned in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// set mode, give one tick at a count, then look at the pad after the pin lag
	task step(input logic [1:0] h, input logic [7:0] c, input logic [15:0] v, input logic dn,
		input logic e);
		wave_mode_hi <= h;
		apb(1'b1, ctrl_a_off, 32'(c));
		count_value <= v;
		count_down <= dn;
		count_tick <= 1'b1;
		@(posedge pclk);
		count_tick <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("pad_a", 32'(e), 32'(pad_a));
	endtask
	task wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		wrap_up;
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, count_tick, count_down, port_data_a, port_data_b} = 7'h00;
		{paddr, pwdata, count_value, wave_mode_hi} = 58'h0;
		match_value_a = 16'h0100;
		match_value_b = 16'h0200;
		capture_value = 16'h0ABC;
		port_dir_a = 1'b1;
		port_dir_b = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ctrl_a_off, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b1, ctrl_a_off, 32'hFF);
		apb(1'b0, ctrl_a_off, 32'h0);
		chk("ctrl", 32'hF3, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		$display("test registers done");
		// every mode: number, class, capture use; top, reload point, slope for all but mode 13
		for (int m = 0; m < 16; m++) begin
			wave_mode_hi <= m[3:2];
			apb(1'b1, ctrl_a_off, 32'(m[1:0]));
			apb(1'b0, state_off, 32'h0);
			chk("mode", 32'(m[3:0]), 32'(rd[3:0]));
			chk("class", 32'(cls_s[m*4+:3]), 32'(rd[6:4]));
			chk("cap", 32'(m > 7 && !m[0]), 32'(capture_is_top));
			if (m != 13) begin
				chk("top", 32'(top_tab[m]), 32'(rd[31:16]));
				chk("top_value", 32'(top_tab[m]), 32'(top_value));
				chk("load", 32'(ld_s[m*4+:2]), 32'(load_point));
				chk("dual", 32'(m inside {[1:3], [8:11]}), 32'(dual_slope));
			end
		end
		// toggle code owns pin a only in the listed pwm modes, never pin b
		for (int i = 0; i < 4; i++) begin
			md = (i == 0) ? 14 : (i == 1) ? 5 : (i == 2) ? 10 : 1;
			wave_mode_hi <= md[3:2];
			apb(1'b1, ctrl_a_off, 32'h50 | 32'(md[1:0]));
			apb(1'b0, state_off, 32'h0);
			chk("own", 32'(md > 9), 32'(rd[11:10]));
		end
		$display("test modes done");
		step(2'h1, 8'h40, 16'h0100, 1'b0, 1'b1);
		apb(1'b0, status_off, 32'h0);
		chk("status", 32'h2, rd);
		chk("irq", 32'h0, 32'(irq));
		apb(1'b1, mask_off, 32'h2);
		@(posedge pclk);
		chk("irq", 32'h1, 32'(irq));
		apb(1'b1, status_off, 32'h2);
		@(posedge pclk);
		chk("irq", 32'h0, 32'(irq));
		step(2'h1, 8'h80, 16'h0100, 1'b0, 1'b0);
		step(2'h1, 8'hC0, 16'h0100, 1'b0, 1'b1);
		step(2'h1, 8'h40, 16'h0100, 1'b0, 1'b0);
		step(2'h1, 8'h40, 16'hFFFF, 1'b0, 1'b0);
		// matches since the clear plus the overflow at max are both pending
		apb(1'b0, status_off, 32'h0);
		chk("status ovf", 32'h3, rd);
		step(2'h3, 8'h82, 16'h0ABC, 1'b0, 1'b1);
		step(2'h3, 8'h82, 16'h0100, 1'b0, 1'b0);
		step(2'h3, 8'hC2, 16'h0100, 1'b0, 1'b1);
		step(2'h3, 8'hC2, 16'h0ABC, 1'b0, 1'b0);
		step(2'h2, 8'hC2, 16'h0100, 1'b0, 1'b1);
		step(2'h2, 8'hC2, 16'h0100, 1'b1, 1'b0);
		step(2'h2, 8'h82, 16'h0100, 1'b1, 1'b1);
		step(2'h2, 8'h82, 16'h0100, 1'b0, 1'b0);
		step(2'h2, 8'h82, 16'h0000, 1'b1, 1'b0);
		match_value_a <= 16'h0ABC;
		step(2'h3, 8'h82, 16'h0ABC, 1'b0, 1'b1);
		// compare at bottom pins a non-inverted dual-slope output low, not set on the way down
		match_value_a <= 16'h0000;
		step(2'h2, 8'h82, 16'h0000, 1'b1, 1'b0);
		$display("test waveform done");
		// released pin shows the port value; no driver without the direction bit
		port_data_a <= 1'b1;
		step(2'h0, 8'h00, 16'h0100, 1'b0, 1'b1);
		port_data_a <= 1'b0;
		port_dir_a <= 1'b0;
		port_dir_b <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("pad_a", 32'h1, 32'(pad_a));
		chk("oe_b", 32'h1, 32'(pin_b_oe));
		// channel b set on match reaches its own pad; pad a stays on its pull-up
		step(2'h1, 8'h30, 16'h0200, 1'b0, 1'b1);
		chk("pad_b", 32'h1, 32'(pad_b));
		$display("test pins done");
		wrap_up;
	end
endmodule
